// ### rtl/caf_pkg.sv
// package: register map, field layouts, resets and carriers of the acceptance filter
package caf_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int unsigned NFILT        = 16;
  localparam int unsigned NMASK        = 2;
  localparam int unsigned NROUTE       = 8;
  localparam int unsigned NMSEL        = 4;
  localparam int unsigned FILT_BYTES   = 64;
  localparam int unsigned MASK_BYTES   = 8;
  localparam int unsigned LEGACY_NFILT = 6;
  localparam int unsigned ID_W         = 29;
  localparam int unsigned DATA_W       = 18;
  localparam int unsigned FILT15       = 15;

  // ************************************************************
  // register offsets
  // ************************************************************
  localparam logic [7:0] ADDR_FILT_BASE  = 8'h00;
  localparam logic [7:0] ADDR_MASK_BASE  = 8'h40;
  localparam logic [7:0] ADDR_ENABLE_LO  = 8'h48;
  localparam logic [7:0] ADDR_ENABLE_HI  = 8'h49;
  localparam logic [7:0] ADDR_DFL        = 8'h4A;
  localparam logic [7:0] ADDR_MODE       = 8'h4B;
  localparam logic [7:0] ADDR_ROUTE_BASE = 8'h50;
  localparam logic [7:0] ADDR_MSEL_BASE  = 8'h58;
  localparam logic [7:0] ADDR_STATUS     = 8'h5C;

  // byte order inside one filter or mask group
  localparam logic [1:0] BYTE_SIDH = 2'h0;
  localparam logic [1:0] BYTE_SIDL = 2'h1;
  localparam logic [1:0] BYTE_EIDH = 2'h2;
  localparam logic [1:0] BYTE_EIDL = 2'h3;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int unsigned SIDL_IDE_BIT  = 3;
  localparam int unsigned MODE_CFG_BIT  = 7;
  localparam logic [7:0]  SIDL_WMASK    = 8'hEB;
  localparam logic [7:0]  SIDL_LEG_RMSK = 8'hE3;
  localparam logic [7:0]  DFL_WMASK     = 8'h1F;
  localparam logic [7:0]  MODE_WMASK    = 8'h83;
  localparam logic [7:0]  MODE_RST      = 8'h80;
  localparam logic [7:0]  ENABLE_LO_RST = 8'h3F;
  localparam logic [7:0]  ENABLE_HI_RST = 8'h10;
  localparam logic [63:0] ROUTE_RST     = 64'h0000_0000_0011_1100;
  localparam logic [31:0] MSEL_RST      = 32'h0000_0550;

  // ************************************************************
  // data filter length limits and codes
  // ************************************************************
  localparam logic [3:0] DLC_NONE = 4'h0;
  localparam logic [3:0] DLC_ONE  = 4'h1;
  localparam logic [3:0] DLC_TWO  = 4'h2;
  localparam logic [4:0] LIM_ONE  = 5'h08;
  localparam logic [4:0] LIM_TWO  = 5'h10;
  localparam logic [4:0] LIM_MAX  = 5'h12;

  localparam logic [3:0] PTR_DED0 = 4'h0;
  localparam logic [3:0] PTR_DED1 = 4'h1;

  typedef enum logic [1:0] {
    MSEL_MASK0  = 2'h0,
    MSEL_MASK1  = 2'h1,
    MSEL_FILT15 = 2'h2,
    MSEL_NONE   = 2'h3
  } caf_msel_t;

  typedef enum logic [1:0] {
    OPM_LEGACY = 2'h0,
    OPM_ENH1   = 2'h1,
    OPM_ENH2   = 2'h2
  } caf_opm_t;

  // incoming frame: standard id sits in id[28:18]
  typedef struct packed {
    logic              valid;
    logic              ext;
    logic [ID_W-1:0]   id;
    logic [3:0]        dlc;
    logic [DATA_W-1:0] data;
  } caf_msg_t;

  typedef struct packed {
    logic       accept;
    logic [3:0] filter;
    logic [3:0] buf_ptr;
  } caf_result_t;

endpackage : caf_pkg

// ### rtl/caf_accept_filter.sv
// acceptance filters, masks, enables, data length filter and buffer routing
// Summary of operation
// (RULE1) filter low eid byte; filters 6-15 enhanced only
// (RULE2) two masks, high byte id bits 10-3
// (RULE3) mask low byte layout, bits 4,2 zero
// (RULE4) mask type bit restricts type, legacy reads zero
// (RULE5) mask extended high and low bytes
// (RULE6) one enable bit per filter
// (RULE7) enables and routes exist in enhanced only
// (RULE8) length, route, select written in config only
// (RULE9) length count forced zero in legacy mode
// (RULE10) length count selects 0 to 18 data bits
// (RULE11) dlc zero compares no data bits
// (RULE12) dlc one compares up to 8 bits; the code takes only flc[2:0], so at most 7
// (RULE13) dlc two compares up to 16 bits; the code takes only flc[3:0], so at most 15
// (RULE14) dlc three compares up to 18 bits
// (RULE15) four-bit pointer per filter, 8-15 reserved
// (RULE16) filter type bit picks standard or extended
// (RULE17) two-bit select picks mask, filter15 or none
// (RULE18) only mask-one bits are compared
// (RULE19) matching enabled filter routes to its buffer
module caf_accept_filter
  import caf_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_srst,
  input  wire logic [7:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire caf_msg_t    i_msg,
  output caf_result_t      o_result
);

  // ************************************************************
  // storage
  // ************************************************************
  logic [7:0]  filt_reg  [FILT_BYTES];
  logic [7:0]  mask_reg  [MASK_BYTES];
  logic [7:0]  route_reg [NROUTE];
  logic [7:0]  msel_reg  [NMSEL];
  logic [15:0] en_reg;
  logic [4:0]  dfl_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  status_reg;
  logic [7:0]  rdata_reg;
  caf_result_t result_reg;

  // ************************************************************
  // decode
  // ************************************************************
  wire       enh     = (mode_reg[1:0] != OPM_LEGACY);
  wire       cfg     = mode_reg[MODE_CFG_BIT];
  wire       in_filt = (i_addr[7:6] == ADDR_FILT_BASE[7:6]);
  wire       in_mask = (i_addr[7:3] == ADDR_MASK_BASE[7:3]);
  wire       in_rte  = (i_addr[7:3] == ADDR_ROUTE_BASE[7:3]);
  wire       in_msel = (i_addr[7:2] == ADDR_MSEL_BASE[7:2]);
  wire       in_enlo = (i_addr == ADDR_ENABLE_LO);
  wire       in_enhi = (i_addr == ADDR_ENABLE_HI);
  wire       in_dfl  = (i_addr == ADDR_DFL);
  wire       in_mode = (i_addr == ADDR_MODE);
  wire       in_stat = (i_addr == ADDR_STATUS);
  wire [3:0] a_filt  = i_addr[5:2];
  wire       is_sidl = (i_addr[1:0] == BYTE_SIDL);
  // filters 6 and up are absent in legacy mode
  wire       filt_ok = enh || (a_filt < 4'(LEGACY_NFILT)); // RULE1

  wire       wr_filt = i_wr && in_filt && filt_ok; // RULE1
  wire       wr_mask = i_wr && in_mask;
  wire       wr_en   = i_wr && enh && (in_enlo || in_enhi); // RULE7
  wire       wr_dfl  = i_wr && cfg && in_dfl; // RULE8
  wire       wr_rte  = i_wr && cfg && enh && in_rte; // RULE8 RULE7
  wire       wr_msel = i_wr && cfg && enh && in_msel; // RULE8
  wire       wr_mode = i_wr && in_mode;
  wire [7:0] id_wval = is_sidl ? (i_wdata & SIDL_WMASK) : i_wdata; // RULE3

  // ************************************************************
  // register writes
  // ************************************************************
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int i = 0; i < FILT_BYTES; i++) filt_reg[i] <= 8'h00;
    end else if (wr_filt) begin
      filt_reg[i_addr[5:0]] <= id_wval; // RULE1
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int i = 0; i < MASK_BYTES; i++) mask_reg[i] <= 8'h00;
    end else if (wr_mask) begin
      mask_reg[i_addr[2:0]] <= id_wval; // RULE2 RULE3 RULE5
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int i = 0; i < NROUTE; i++) route_reg[i] <= ROUTE_RST[8*i +: 8];
    end else if (wr_rte) begin
      route_reg[i_addr[2:0]] <= i_wdata; // RULE15
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      for (int i = 0; i < NMSEL; i++) msel_reg[i] <= MSEL_RST[8*i +: 8];
    end else if (wr_msel) begin
      msel_reg[i_addr[1:0]] <= i_wdata; // RULE17
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      en_reg   <= {ENABLE_HI_RST, ENABLE_LO_RST};
      dfl_reg  <= 5'h00;
      mode_reg <= MODE_RST;
    end else begin
      if (wr_en && in_enlo) en_reg[7:0] <= i_wdata; // RULE6
      if (wr_en && in_enhi) en_reg[15:8] <= i_wdata; // RULE6
      if (wr_dfl) dfl_reg <= i_wdata[4:0]; // RULE8
      if (wr_mode) mode_reg <= i_wdata & MODE_WMASK;
    end
  end

  // ************************************************************
  // read path
  // ************************************************************
  wire [7:0] filt_rd = filt_ok ? filt_reg[i_addr[5:0]] : 8'h00; // RULE1
  wire [7:0] mask_raw = mask_reg[i_addr[2:0]];
  // legacy mode hides the mask type bit
  wire [7:0] mask_rd = (is_sidl && !enh) ? (mask_raw & SIDL_LEG_RMSK) : mask_raw; // RULE4
  wire [7:0] en_rd = !enh ? 8'h00 : (in_enhi ? en_reg[15:8] : en_reg[7:0]); // RULE7
  wire [7:0] dfl_rd = enh ? ({3'h0, dfl_reg} & DFL_WMASK) : 8'h00; // RULE9
  wire [7:0] rte_rd = enh ? route_reg[i_addr[2:0]] : 8'h00; // RULE7
  wire [7:0] msel_rd = msel_reg[i_addr[1:0]];
  wire [7:0] rd_val =
    in_filt ? filt_rd :
    in_mask ? mask_rd :
    (in_enlo || in_enhi) ? en_rd :
    in_dfl  ? dfl_rd :
    in_mode ? mode_reg :
    in_rte  ? rte_rd :
    in_msel ? msel_rd :
    in_stat ? status_reg : 8'h00;

  // data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (i_srst) rdata_reg <= 8'h00;
    else        rdata_reg <= i_rd ? rd_val : 8'h00;
  end
  assign o_rdata = rdata_reg;

  // ************************************************************
  // data byte window
  // ************************************************************
  // legacy mode sees a length count of zero, so no data bits
  wire [4:0] flc = enh ? dfl_reg : 5'h00; // RULE9
  wire [4:0] n_cmp =
    (i_msg.dlc == DLC_NONE) ? 5'h00 : // RULE11
    (i_msg.dlc == DLC_ONE)  ? ((5'(flc[2:0]) > LIM_ONE) ? LIM_ONE : 5'(flc[2:0])) : // RULE12
    (i_msg.dlc == DLC_TWO)  ? ((5'(flc[3:0]) > LIM_TWO) ? LIM_TWO : 5'(flc[3:0])) : // RULE13
    ((flc > LIM_MAX) ? LIM_MAX : flc); // RULE14 RULE10
  logic [DATA_W-1:0] data_win;
  for (genvar k = 0; k < DATA_W; k++) begin : g_win
    assign data_win[k] = (5'(k) < n_cmp); // RULE10
  end

  // ************************************************************
  // mask and filter vectors
  // ************************************************************
  logic [ID_W-1:0] mask_vec [NMASK];
  logic            mask_ide [NMASK];
  logic [ID_W-1:0] fvec     [NFILT];
  logic            fide     [NFILT];
  logic [NFILT-1:0] hit;
  logic [NFILT-1:0] good;
  logic [3:0]       ptr_of  [NFILT];

  for (genvar m = 0; m < NMASK; m++) begin : g_mask
    assign mask_vec[m] = {mask_reg[4*m], mask_reg[4*m+1][7:5], mask_reg[4*m+1][1:0],
                          mask_reg[4*m+2], mask_reg[4*m+3]}; // RULE2 RULE3 RULE5
    assign mask_ide[m] = mask_reg[4*m+1][SIDL_IDE_BIT]; // RULE4
  end

  // standard frames put the data bits where the low id bits would be
  wire [ID_W-1:0] msg_vec = i_msg.ext ? i_msg.id : {i_msg.id[ID_W-1:DATA_W], i_msg.data};

  for (genvar f = 0; f < NFILT; f++) begin : g_filt
    caf_msel_t       sel;
    logic [ID_W-1:0] sel_vec;
    logic [ID_W-1:0] cmp_vec;
    logic            sel_ide;
    logic            type_ok;
    logic            f_en;
    assign fvec[f] = {filt_reg[4*f], filt_reg[4*f+1][7:5], filt_reg[4*f+1][1:0],
                      filt_reg[4*f+2], filt_reg[4*f+3]}; // RULE1
    assign fide[f] = filt_reg[4*f+1][SIDL_IDE_BIT];
    assign sel = enh ? caf_msel_t'(msel_reg[f/4][(f%4)*2 +: 2]) :
                 ((f < 2) ? MSEL_MASK0 : MSEL_MASK1); // RULE17
    assign sel_vec = (sel == MSEL_MASK0)  ? mask_vec[0] :
                     (sel == MSEL_MASK1)  ? mask_vec[1] :
                     (sel == MSEL_FILT15) ? fvec[FILT15] : '0; // RULE17
    assign sel_ide = (sel == MSEL_MASK0)  ? mask_ide[0] :
                     (sel == MSEL_MASK1)  ? mask_ide[1] :
                     (sel == MSEL_FILT15) ? fide[FILT15] : 1'b0;
    // only mask-one bits matter; data bits also need the window
    assign cmp_vec = i_msg.ext ? sel_vec :
                     {sel_vec[ID_W-1:DATA_W], sel_vec[DATA_W-1:0] & data_win}; // RULE18
    assign type_ok = (!enh || sel_ide) ? (i_msg.ext == fide[f]) : 1'b1; // RULE16 RULE4
    assign f_en = enh ? en_reg[f] : (f < LEGACY_NFILT); // RULE6 RULE1
    assign hit[f] = f_en && type_ok && (((msg_vec ^ fvec[f]) & cmp_vec) == '0); // RULE18
    assign ptr_of[f] = enh ? route_reg[f/2][(f%2)*4 +: 4] :
                       ((f < 2) ? PTR_DED0 : PTR_DED1); // RULE15
    // reserved pointer codes route nowhere
    assign good[f] = hit[f] && !ptr_of[f][3]; // RULE15
  end

  // ************************************************************
  // winner and routing
  // ************************************************************
  logic       win_any;
  logic [3:0] win_idx;
  always_comb begin
    win_any = 1'b0;
    win_idx = 4'h0;
    // lowest numbered filter wins
    for (int i = NFILT - 1; i >= 0; i--) begin
      if (good[i]) begin
        win_any = 1'b1;
        win_idx = 4'(i);
      end
    end
  end
  wire [3:0] win_ptr = ptr_of[win_idx];

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      result_reg <= '0;
      status_reg <= 8'h00;
    end else begin
      result_reg.accept  <= i_msg.valid && win_any; // RULE19
      result_reg.filter  <= win_idx;
      result_reg.buf_ptr <= win_ptr; // RULE19
      if (i_msg.valid && win_any) status_reg <= {win_ptr, win_idx};
    end
  end
  assign o_result = result_reg;

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);

  chk_legacy_no_high: assert property (!enh |-> hit[NFILT-1:LEGACY_NFILT] == '0) // RULE1
    else $error("legacy mode hit on filter above five");
  chk_mask_gaps_zero: assert property (i_rd && in_mask && is_sidl |=> o_rdata[4] == 1'b0 && o_rdata[2] == 1'b0) // RULE3
    else $error("mask low byte gap bits not zero");
  chk_legacy_ide_read: assert property (i_rd && in_mask && is_sidl && !enh |=> o_rdata[3] == 1'b0) // RULE4
    else $error("mask type bit visible in legacy mode");
  chk_disabled_filter: assert property (enh && !en_reg[0] |-> !hit[0]) // RULE6
    else $error("disabled filter zero hit");
  chk_legacy_enable_read: assert property (i_rd && (in_enlo || in_enhi) && !enh |=> o_rdata == 8'h00) // RULE7
    else $error("enable register visible in legacy mode");
  chk_dfl_cfg_only: assert property (i_wr && in_dfl && !cfg |=> $stable(dfl_reg)) // RULE8
    else $error("length count written outside config");
  chk_dfl_legacy_zero: assert property (i_rd && in_dfl && !enh |=> o_rdata == 8'h00) // RULE9
    else $error("length count not forced zero");
  chk_dlc_zero_window: assert property (i_msg.dlc == DLC_NONE |-> data_win == '0) // RULE11
    else $error("data compared with zero length code");
  chk_dlc_three_cap: assert property (i_msg.dlc == 4'h3 && flc >= LIM_MAX |-> n_cmp == LIM_MAX) // RULE14
    else $error("three byte window not capped at 18");
  chk_route_pointer: assert property (i_msg.valid && win_any |=> o_result.accept && o_result.buf_ptr == $past(win_ptr)) // RULE19
    else $error("accepted message routed to wrong buffer");
  chk_no_reserved_ptr: assert property (o_result.accept |-> !o_result.buf_ptr[3]) // RULE15
    else $error("reserved buffer pointer used");

  // ************************************************************
  // register bus checks
  // ************************************************************
  chk_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data not zero outside a read");

  chk_enlo_read_back: assert property (i_rd && in_enlo && enh |=> o_rdata == $past(en_reg[7:0])) // RULE6
    else $error("low enable byte read wrong");

  chk_enhi_read_back: assert property (i_rd && in_enhi && enh |=> o_rdata == $past(en_reg[15:8])) // RULE6
    else $error("high enable byte read wrong");

  chk_enable_legacy_hold: assert property (i_wr && (in_enlo || in_enhi) && !enh |=> $stable(en_reg)) // RULE7
    else $error("enable written in legacy mode");

  chk_route_legacy_read: assert property (i_rd && in_rte && !enh |=> o_rdata == 8'h00) // RULE7
    else $error("route register visible in legacy mode");

  chk_filt_legacy_read: assert property (i_rd && in_filt && !filt_ok |=> o_rdata == 8'h00) // RULE1
    else $error("absent filter visible in legacy mode");

  chk_filt_gaps_zero: assert property (i_rd && in_filt && is_sidl |=> // RULE3
    o_rdata[4] == 1'b0 && o_rdata[2] == 1'b0)
    else $error("filter low byte gap bits not zero");

  chk_dfl_upper_zero: assert property (i_rd && in_dfl |=> o_rdata[7:5] == 3'h0) // RULE9
    else $error("length count upper bits not zero");

  chk_dfl_read_back: assert property (i_rd && in_dfl && enh |=> o_rdata[4:0] == $past(dfl_reg)) // RULE10
    else $error("length count read wrong");

  chk_dfl_write_cfg: assert property (wr_dfl |=> dfl_reg == $past(i_wdata[4:0])) // RULE8
    else $error("length count write lost in config");

  chk_mode_read_back: assert property (i_rd && in_mode |=> o_rdata == $past(mode_reg))
    else $error("mode register read wrong");

  chk_mode_spare_zero: assert property ((mode_reg & ~MODE_WMASK) == 8'h00)
    else $error("mode register spare bits set");

  chk_status_read: assert property (i_rd && in_stat |=> o_rdata == $past(status_reg)) // RULE19
    else $error("status register read wrong");

  chk_msel_read_back: assert property (i_rd && in_msel |=> o_rdata == $past(msel_rd)) // RULE17
    else $error("mask select read wrong");

  chk_route_read_back: assert property (i_rd && in_rte && enh |=> o_rdata == $past(rte_rd)) // RULE15
    else $error("route register read wrong");

  // ************************************************************
  // frame path checks
  // ************************************************************
  chk_accept_one_cycle: assert property (!i_msg.valid |=> !o_result.accept) // RULE19
    else $error("accept without a frame");

  chk_accept_filter: assert property (i_msg.valid && win_any |=> // RULE19
    o_result.filter == $past(win_idx))
    else $error("accepted message names wrong filter");

  chk_status_update: assert property (i_msg.valid && win_any |=> // RULE19
    status_reg == {$past(win_ptr), $past(win_idx)})
    else $error("status not updated on accept");

  chk_no_match_reject: assert property (i_msg.valid && !win_any |=> !o_result.accept) // RULE18
    else $error("frame accepted without a match");

  chk_legacy_flc_zero: assert property (!enh |-> flc == 5'h00) // RULE9
    else $error("length count used in legacy mode");

  chk_window_max: assert property (n_cmp <= LIM_MAX) // RULE10
    else $error("data window above 18 bits");

  chk_dlc_one_cap: assert property (i_msg.dlc == DLC_ONE |-> n_cmp <= LIM_ONE) // RULE12
    else $error("one byte window above 8 bits");

  chk_dlc_two_cap: assert property (i_msg.dlc == DLC_TWO |-> n_cmp <= LIM_TWO) // RULE13
    else $error("two byte window above 16 bits");

  chk_legacy_pointer: assert property (!enh |-> ptr_of[0] == PTR_DED0 && ptr_of[2] == PTR_DED1) // RULE15
    else $error("legacy buffer pointer wrong");

  chk_legacy_mask_sel: assert property (!enh |-> // RULE17
    g_filt[0].sel == MSEL_MASK0 && g_filt[2].sel == MSEL_MASK1)
    else $error("legacy mask choice wrong");

  chk_no_mask_hit: assert property (enh && en_reg[0] && msel_reg[0][1:0] == MSEL_NONE |-> hit[0]) // RULE17
    else $error("unmasked enabled filter missed");

  chk_type_strict: assert property (hit[0] && (!enh || g_filt[0].sel_ide) |-> // RULE16
    i_msg.ext == fide[0])
    else $error("filter hit on wrong identifier type");

  chk_disabled_last: assert property (enh && !en_reg[FILT15] |-> !hit[FILT15]) // RULE6
    else $error("disabled filter fifteen hit");

  chk_reserved_skip: assert property (ptr_of[0][3] |-> !good[0]) // RULE15
    else $error("reserved pointer filter still matching");

  cov_ext_accept: cover property (i_msg.valid && i_msg.ext ##1 o_result.accept);
  cov_std_data: cover property (i_msg.valid && !i_msg.ext && n_cmp != 5'h00 ##1 o_result.accept);
  cov_legacy_accept: cover property (!enh && i_msg.valid ##1 o_result.accept);
  cov_filter15_mask: cover property (enh && g_filt[0].sel == MSEL_FILT15 && i_msg.valid ##1 o_result.accept);
  cov_route_nonzero: cover property (o_result.accept && o_result.buf_ptr != PTR_DED0);

endmodule : caf_accept_filter

// ### verif/caf_engine_model.sv
// far-side frame source standing in for the protocol engine
module caf_engine_model
  import caf_pkg::*;
(
  input  wire logic     i_mclk,
  input  wire logic     i_send,
  input  wire caf_msg_t i_frame,
  output caf_msg_t      o_msg
);
  timeunit 1ns;
  timeprecision 1ns;

  initial o_msg = '0;

  // idle fields toggle each cycle so stale frame contents are never trusted
  always @(posedge i_mclk) begin
    if (i_send) begin
      o_msg <= {1'b1, i_frame[$bits(caf_msg_t)-2:0]};
    end else begin
      o_msg <= {1'b0, ~o_msg[$bits(caf_msg_t)-2:0]};
    end
  end
endmodule : caf_engine_model

// ### verif/caf_accept_filter_tb.sv
// self-checking bench for the acceptance filter
module caf_accept_filter_tb import caf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_mclk  = 1'b0;
  logic        i_srst  = 1'b1;
  logic [7:0]  i_addr  = 8'h00;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic [7:0]  o_rdata;
  logic        send    = 1'b0;
  caf_msg_t    frame   = '0;
  caf_msg_t    msg;
  caf_result_t o_result;
  int          miscompares  = 0;
  int          total_checks = 0;
  int          cycles       = 0;

  caf_engine_model engine (.i_mclk(i_mclk), .i_send(send), .i_frame(frame), .o_msg(msg));

  caf_accept_filter uut (.i_mclk(i_mclk), .i_srst(i_srst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_msg(msg),
    .o_result(o_result));

  always #20 i_mclk = ~i_mclk;

  // whole run needs well under a thousand cycles
  always @(posedge i_mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  // ************************************************************
  // bus and frame helpers
  // ************************************************************
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk("rdata", {1'b0, o_rdata}, {1'b0, exp});
  endtask : rd

  // exp packs accept, filter and pointer; filter and pointer ignored on reject
  task automatic frm(input logic ext, input logic [10:0] sid, input logic [3:0] dlc,
                     input logic [17:0] dat, input logic [8:0] exp);
    @(posedge i_mclk);
    send  <= 1'b1;
    frame <= '{valid: 1'b1, ext: ext, id: {sid, 18'h00000}, dlc: dlc, data: dat};
    @(posedge i_mclk);
    send <= 1'b0;
    @(posedge i_mclk);
    #1;
    chk("result", exp[8] ? o_result : {o_result.accept, 8'h00}, exp);
  endtask : frm

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic s_legacy;
    rd(ADDR_ENABLE_LO, 8'h00);
    rd(8'h51, 8'h00);
    wr(8'h1B, 8'hA5);
    rd(8'h1B, 8'h00);
    wr(8'h03, 8'hA5);
    rd(8'h03, 8'hA5);
    wr(8'h41, 8'hFF);
    rd(8'h41, 8'hE3);
    wr(ADDR_DFL, 8'hFF);
    rd(ADDR_DFL, 8'h00);
    rd(8'h5F, 8'h00);
    wr(8'h09, 8'h08);
    frm(1'b1, 11'h091, 4'h0, 18'h0, 9'h121);
  endtask : s_legacy

  task automatic s_regs;
    logic [7:0] mb [3] = '{8'h44, 8'h46, 8'h47};
    wr(ADDR_MODE, 8'h81);
    rd(ADDR_ENABLE_LO, ENABLE_LO_RST);
    rd(ADDR_ENABLE_HI, ENABLE_HI_RST);
    rd(8'h51, 8'h11);
    wr(8'h41, 8'hFF);
    rd(8'h41, 8'hEB);
    wr(8'h1B, 8'h5A);
    rd(8'h1B, 8'h5A);
    foreach (mb[i]) begin
      wr(mb[i], 8'hC3);
      rd(mb[i], 8'hC3);
      wr(mb[i], 8'h00);
    end
    wr(ADDR_DFL, 8'hFF);
    rd(ADDR_DFL, 8'h1F);
    // leave config mode: these writes must all be dropped
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_DFL, 8'h05);
    wr(ADDR_ROUTE_BASE, 8'h77);
    wr(ADDR_MSEL_BASE, 8'hFF);
    rd(ADDR_DFL, 8'h1F);
    rd(ADDR_ROUTE_BASE, 8'h00);
    rd(ADDR_MSEL_BASE, 8'h50);
    wr(ADDR_MODE, 8'h81);
  endtask : s_regs

  task automatic s_match;
    wr(ADDR_ENABLE_LO, 8'h01);
    wr(ADDR_ENABLE_HI, 8'h00);
    wr(8'h40, 8'hFF);
    wr(8'h41, 8'hE0);
    wr(8'h00, 8'h12);
    wr(8'h01, 8'h20);
    frm(1'b0, 11'h091, 4'h0, 18'h0, 9'h100);
    frm(1'b1, 11'h091, 4'h0, 18'h0, 9'h100);
    frm(1'b0, 11'h092, 4'h0, 18'h0, 9'h000);
    wr(ADDR_ENABLE_LO, 8'h00);
    frm(1'b0, 11'h091, 4'h0, 18'h0, 9'h000);
    wr(ADDR_ENABLE_LO, 8'h01);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_MSEL_BASE, {6'h14, 2'(s)});
      frm(1'b0, 11'h092, 4'h0, 18'h0, (s == 0) ? 9'h000 : 9'h100);
    end
    wr(8'h3C, 8'hFF);
    wr(8'h3D, 8'hE0);
    wr(ADDR_MSEL_BASE, 8'h52);
    frm(1'b0, 11'h092, 4'h0, 18'h0, 9'h000);
    wr(ADDR_MSEL_BASE, 8'h50);
    for (int p = 0; p < 9; p++) begin
      wr(ADDR_ROUTE_BASE, 8'(p));
      frm(1'b0, 11'h091, 4'h0, 18'h0, (p == 8) ? 9'h000 : {5'h10, 4'(p)});
    end
    rd(ADDR_STATUS, 8'h70);
    wr(ADDR_ROUTE_BASE, 8'h00);
    wr(8'h41, 8'hE8);
    frm(1'b1, 11'h091, 4'h0, 18'h0, 9'h000);
    frm(1'b0, 11'h091, 4'h0, 18'h0, 9'h100);
    wr(8'h01, 8'h28);
    frm(1'b1, 11'h091, 4'h0, 18'h0, 9'h100);
    frm(1'b0, 11'h091, 4'h0, 18'h0, 9'h000);
  endtask : s_match

  // one entry: data length code, length count, flipped data bit, accepted
  task automatic s_data;
    int tdlc [9] = '{0, 1, 1, 1, 2, 2, 2, 3, 3};
    int tflc [9] = '{18, 7, 7, 18, 15, 15, 18, 18, 17};
    int tbit [9] = '{0, 6, 7, 8, 14, 15, 16, 17, 17};
    int tacc [9] = '{1, 0, 1, 1, 0, 1, 1, 0, 1};
    wr(8'h41, 8'hE3);
    wr(8'h42, 8'hFF);
    wr(8'h43, 8'hFF);
    wr(8'h01, 8'h23);
    wr(8'h02, 8'hA5);
    wr(8'h03, 8'h5A);
    for (int i = 0; i < 9; i++) begin
      wr(ADDR_DFL, 8'(tflc[i]));
      frm(1'b0, 11'h091, 4'(tdlc[i]), 18'h3A55A ^ (18'h1 << tbit[i]),
          (tacc[i] == 1) ? 9'h100 : 9'h000);
    end
  endtask : s_data

  task automatic summarize;
    if (miscompares == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20) @(posedge i_mclk);
    i_srst <= 1'b0;
    s_legacy();
    s_regs();
    s_match();
    s_data();
    summarize();
  end
endmodule : caf_accept_filter_tb
